// ===== hw/amsc_pkg.sv
/*
 * Shared constants for the alt-mode strap and control-pin decoder.
 * Assumes a 20 MHz system clock and four-level straps given as 2-bit codes.
 */
`default_nettype none
package amsc_pkg;
    // ---------------------------------------------------------------
    // strap levels
    // ---------------------------------------------------------------
    localparam logic [1:0] AMSC_LVL_0 = 2'h0;
    localparam logic [1:0] AMSC_LVL_F = 2'h3;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int AMSC_CLK_HZ = 20000000;
    localparam int AMSC_HPD_LOW_US = 2000;
    localparam int AMSC_HPD_LOW_CYC = AMSC_HPD_LOW_US * (AMSC_CLK_HZ / 1000000);
    localparam int AMSC_HPD_CNT_W = 16;
    // ---------------------------------------------------------------
    // values after reset
    // ---------------------------------------------------------------
    localparam logic [1:0] AMSC_RST_STRAP = 2'h0;
    localparam logic [3:0] AMSC_RST_GAIN = 4'h0;
    localparam logic [1:0] AMSC_RST_ADDR = 2'h0;
    localparam logic AMSC_RST_LATCHED = 1'b0;
    localparam logic [AMSC_HPD_CNT_W-1:0] AMSC_RST_CNT = 16'h0000;
endpackage
`default_nettype wire

// ===== hw/amsc_top.sv
/*
 * Alt-mode strap and control-pin decoder: straps, pin muxing between
 * direct control and the serial port, hot-plug timeout, aux routing,
 * and the small gain register that each receiver group uses.
 * Assumes synchronous inputs, straps stable across reset release, and an
 * external serial-port engine that supplies the dp enable register bit.
 */
`default_nettype none
module amsc_top #(
    parameter int HPD_LOW_CYC = amsc_pkg::AMSC_HPD_LOW_CYC
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [1:0] i_bus_sel_strap,
    input wire logic [1:0] i_dp_gain_sel_lo,
    input wire logic [1:0] i_dp_gain_sel_hi,
    input wire logic [1:0] i_up_gain_sel_lo,
    input wire logic [1:0] i_up_gain_sel_hi,
    input wire logic [1:0] i_down_gain_sel_lo,
    input wire logic [1:0] i_down_gain_sel_hi,
    input wire logic i_shared_clk_pin,
    input wire logic i_shared_data_pin,
    input wire logic i_path_en_pin,
    input wire logic i_aux_listen_ctl,
    input wire logic i_reg_dp_en,
    input wire logic i_aux_pos,
    input wire logic i_aux_neg,
    input wire logic i_usb_in_use,
    output logic o_serial_mode,
    output logic o_flip,
    output logic o_usb_path_ctl,
    output logic o_serial_clk,
    output logic o_serial_data,
    output logic o_dp_en,
    output logic o_dp_lanes_en,
    output logic o_aux_switch_closed,
    output logic o_snoop_en,
    output logic [1:0] o_target_addr,
    output logic [3:0] o_dp_gain,
    output logic [3:0] o_up_gain,
    output logic [3:0] o_down_gain,
    output logic o_down_gain_valid,
    output logic o_sbu1_pos,
    output logic o_sbu1_neg,
    output logic o_sbu2_pos,
    output logic o_sbu2_neg
);
    import amsc_pkg::*;

    // ---------------------------------------------------------------
    // strap capture
    // ---------------------------------------------------------------
    logic latched;
    logic [1:0] bus_sel;
    logic [1:0] target_addr;
    logic [3:0] dp_gain;
    logic [3:0] up_gain;
    logic [3:0] down_gain;

    // address from straps
    // any level other than zero reads as a one, so F and 0 give both values
    wire [1:0] next_target_addr = {
        i_dp_gain_sel_lo != AMSC_LVL_0,
        i_up_gain_sel_lo != AMSC_LVL_0
    };

    // latch once after release
    // straps are caught on the first edge after reset, never in reset itself
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            latched <= AMSC_RST_LATCHED;
            bus_sel <= AMSC_RST_STRAP;
            target_addr <= AMSC_RST_ADDR;
        end else if (!latched) begin
            latched <= 1'b1;
            bus_sel <= i_bus_sel_strap;
            target_addr <= next_target_addr;
        end
    end

    // ---------------------------------------------------------------
    // gain straps
    // ---------------------------------------------------------------
    // gains follow the straps live so the board can retune them
    // dp gain combine
    amsc_gain_reg #(
        .SEL_W(2)
    ) u_dp_gain (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_sel_lo(i_dp_gain_sel_lo),
        .i_sel_hi(i_dp_gain_sel_hi),
        .o_gain(dp_gain)
    );

    amsc_gain_reg #(
        .SEL_W(2)
    ) u_up_gain (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_sel_lo(i_up_gain_sel_lo),
        .i_sel_hi(i_up_gain_sel_hi),
        .o_gain(up_gain)
    );

    amsc_gain_reg #(
        .SEL_W(2)
    ) u_down_gain (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_sel_lo(i_down_gain_sel_lo),
        .i_sel_hi(i_down_gain_sel_hi),
        .o_gain(down_gain)
    );

    // ---------------------------------------------------------------
    // pin muxing
    // ---------------------------------------------------------------
    wire serial_mode = latched && (bus_sel != AMSC_LVL_0);
    wire direct_mode = latched && (bus_sel == AMSC_LVL_0);

    // ---------------------------------------------------------------
    // plug-detect timeout
    // ---------------------------------------------------------------
    logic [AMSC_HPD_CNT_W-1:0] low_cnt;
    logic hpd_lost;
    wire hpd_low = serial_mode && !i_path_en_pin;
    // limit is cut to the counter width: keep it below 65536 cycles
    wire [AMSC_HPD_CNT_W-1:0] cnt_lim = HPD_LOW_CYC[AMSC_HPD_CNT_W-1:0];
    wire at_limit = (low_cnt == cnt_lim);
    wire [AMSC_HPD_CNT_W-1:0] next_low_cnt = low_cnt + AMSC_HPD_CNT_W'(1);

    // low longer than limit
    // strictly greater: lanes drop one cycle after the count reaches the limit
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            low_cnt <= AMSC_RST_CNT;
            hpd_lost <= 1'b0;
        end else if (!hpd_low) begin
            low_cnt <= AMSC_RST_CNT;
            hpd_lost <= 1'b0;
        end else if (!at_limit) begin
            low_cnt <= next_low_cnt;
        end else begin
            hpd_lost <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // shared pin roles
    // ---------------------------------------------------------------
    // clock pin role
    assign o_flip = direct_mode & i_shared_clk_pin;
    assign o_serial_clk = serial_mode & i_shared_clk_pin;
    assign o_usb_path_ctl = direct_mode & i_shared_data_pin;
    assign o_serial_data = serial_mode & i_shared_data_pin;

    // ---------------------------------------------------------------
    // dp enable and lanes
    // ---------------------------------------------------------------
    // dp enable source
    assign o_dp_en = direct_mode ? i_path_en_pin : (serial_mode & i_reg_dp_en);
    assign o_dp_lanes_en = o_dp_en & ~hpd_lost;
    assign o_aux_switch_closed = o_dp_en;

    // ---------------------------------------------------------------
    // snoop and status
    // ---------------------------------------------------------------
    // snoop control
    // in serial mode the listen pin is reserved, snooping stays on
    assign o_snoop_en = direct_mode ? ~i_aux_listen_ctl : serial_mode;
    assign o_serial_mode = serial_mode;
    assign o_target_addr = serial_mode ? target_addr : AMSC_RST_ADDR;
    assign o_dp_gain = dp_gain;
    assign o_up_gain = up_gain;
    assign o_down_gain = down_gain;
    assign o_down_gain_valid = i_usb_in_use;

    // ---------------------------------------------------------------
    // aux routing
    // ---------------------------------------------------------------
    // aux routing by flip
    wire aux_on = o_aux_switch_closed;
    wire flipped = direct_mode & i_shared_clk_pin;
    assign o_sbu1_pos = aux_on & ~flipped & i_aux_pos;
    assign o_sbu1_neg = aux_on & ~flipped & i_aux_neg;
    assign o_sbu2_pos = aux_on & flipped & i_aux_pos;
    assign o_sbu2_neg = aux_on & flipped & i_aux_neg;
endmodule

// ---------------------------------------------------------------
// gain register
// ---------------------------------------------------------------
// one copy per receiver group; the strap pair is kept as one code
module amsc_gain_reg #(
    parameter int SEL_W = 2
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [SEL_W-1:0] i_sel_lo,
    input wire logic [SEL_W-1:0] i_sel_hi,
    output logic [2*SEL_W-1:0] o_gain
);
    import amsc_pkg::*;

    localparam int GAIN_W = 2 * SEL_W;
    localparam logic [GAIN_W-1:0] RST_GAIN = GAIN_W'(AMSC_RST_GAIN);

    // hi strap is the upper half of the code, lo strap the lower
    wire [GAIN_W-1:0] next_gain = {i_sel_hi, i_sel_lo};

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_gain <= RST_GAIN;
        end else begin
            o_gain <= next_gain;
        end
    end
endmodule
`default_nettype wire

// ===== tb/amsc_board_model.sv
/* board and sink stand-in: plug detect and address strap; bench commands it */
`default_nettype none
module amsc_board_model (
    input wire logic i_clk,
    input wire logic i_plug,
    input wire logic i_addr0,
    output logic o_plug_detect,
    output logic [1:0] o_addr0_strap
);
    timeunit 1ns;
    timeprecision 1ps;
    import amsc_pkg::*;
    logic plug_q = 1'b0;
    assign o_addr0_strap = i_addr0 ? AMSC_LVL_F : AMSC_LVL_0;
    assign o_plug_detect = plug_q;
    always @(posedge i_clk) begin
        plug_q <= i_plug;
    end
endmodule
`default_nettype wire

// ===== tb/amsc_properties.sv
/* port checker for the strap decoder; assumes one clock, bound to amsc_top */
`default_nettype none
module amsc_properties #(
    parameter int HPD_LOW_CYC = amsc_pkg::AMSC_HPD_LOW_CYC
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_shared_clk_pin,
    input wire logic i_shared_data_pin,
    input wire logic i_path_en_pin,
    input wire logic i_aux_listen_ctl,
    input wire logic i_reg_dp_en,
    input wire logic i_aux_pos,
    input wire logic i_aux_neg,
    input wire logic [1:0] i_dp_gain_sel_lo,
    input wire logic [1:0] i_dp_gain_sel_hi,
    input wire logic [1:0] o_target_addr,
    input wire logic o_serial_mode,
    input wire logic o_flip,
    input wire logic o_usb_path_ctl,
    input wire logic o_serial_clk,
    input wire logic o_serial_data,
    input wire logic o_dp_en,
    input wire logic o_dp_lanes_en,
    input wire logic o_aux_switch_closed,
    input wire logic o_snoop_en,
    input wire logic o_sbu1_pos,
    input wire logic o_sbu1_neg,
    input wire logic o_sbu2_pos,
    input wire logic o_sbu2_neg,
    input wire logic [3:0] o_dp_gain
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // straps latch on the first edge, so modes count from the second
    logic [1:0] age;
    logic [15:0] low_cnt;
    wire logic dir = age != 2'h0 && !o_serial_mode;
    wire logic ser = age != 2'h0 && o_serial_mode;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            age <= 2'h0;
            low_cnt <= 16'h0000;
        end else begin
            age <= (age == 2'h3) ? age : age + 2'h1;
            low_cnt <= i_path_en_pin ? 16'h0000 : low_cnt + 16'h0001;
        end
    end
    property p_pins; age != 2'h0 |-> (o_serial_mode ? o_serial_clk : o_flip) == i_shared_clk_pin
        && (o_serial_mode ? o_serial_data : o_usb_path_ctl) == i_shared_data_pin; endproperty
    a_pins: assert property (p_pins) else $error("shared pin routing");
    property p_dp_pin; dir |-> o_dp_en == i_path_en_pin; endproperty
    a_dp_pin: assert property (p_dp_pin) else $error("dp enable pin");
    property p_dp_reg; ser |-> o_dp_en == i_reg_dp_en; endproperty
    a_dp_reg: assert property (p_dp_reg) else $error("dp enable reg");
    property p_lost; ser && low_cnt > HPD_LOW_CYC + 2 |-> !o_dp_lanes_en
        && o_aux_switch_closed == o_dp_en; endproperty
    a_lost: assert property (p_lost) else $error("plug loss");
    // lanes must not drop before the low time has run out
    property p_kept; ser && o_dp_en && low_cnt < HPD_LOW_CYC |-> o_dp_lanes_en; endproperty
    a_kept: assert property (p_kept) else $error("lanes dropped early");
    property p_gain; age != 2'h0 |-> o_dp_gain == $past({i_dp_gain_sel_hi, i_dp_gain_sel_lo});
    endproperty
    a_gain: assert property (p_gain) else $error("dp gain");
    property p_hold; age == 2'h3 |-> $stable(o_target_addr) && $stable(o_serial_mode); endproperty
    a_hold: assert property (p_hold) else $error("latched straps moved");
    property p_aux; age != 2'h0 && o_aux_switch_closed |-> {i_aux_pos, i_aux_neg}
        == (o_flip ? {o_sbu2_pos, o_sbu2_neg} : {o_sbu1_pos, o_sbu1_neg}); endproperty
    a_aux: assert property (p_aux) else $error("aux routing");
    property p_snoop; dir |-> o_snoop_en == !i_aux_listen_ctl; endproperty
    a_snoop: assert property (p_snoop) else $error("snoop control");
    c_lost: cover property (ser && o_dp_en && !o_dp_lanes_en);
    c_flip: cover property (dir && o_flip && o_dp_en);
    c_addr: cover property (ser && o_target_addr == 2'h3);
endmodule
bind amsc_top amsc_properties #(.HPD_LOW_CYC(HPD_LOW_CYC)) u_props (.*);
`default_nettype wire

// ===== tb/test_altmode_strap_control.sv
/* bench for the strap decoder; assumes the board model feeds plug and addr strap */
`default_nettype none
module test_altmode_strap_control;
    timeunit 1ns;
    timeprecision 1ps;
    import amsc_pkg::*;
    localparam int LOW = 20;
    logic i_clk = 1'b0, i_nrst = 1'b0, plug = 1'b0, addr0 = 1'b0;
    logic [1:0] i_bus_sel_strap = 2'h0, i_dp_gain_sel_lo = 2'h0, i_dp_gain_sel_hi = 2'h0;
    logic [1:0] i_up_gain_sel_hi = 2'h0, i_down_gain_sel_lo = 2'h0, i_down_gain_sel_hi = 2'h0;
    logic i_shared_clk_pin = 1'b0, i_shared_data_pin = 1'b0, i_aux_listen_ctl = 1'b0;
    logic i_reg_dp_en = 1'b0, i_aux_pos = 1'b1, i_aux_neg = 1'b0, i_usb_in_use = 1'b0;
    wire logic i_path_en_pin, o_serial_mode, o_flip, o_usb_path_ctl, o_serial_clk, o_dp_en;
    wire logic o_serial_data, o_dp_lanes_en, o_aux_switch_closed, o_snoop_en, o_down_gain_valid;
    wire logic o_sbu1_pos, o_sbu1_neg, o_sbu2_pos, o_sbu2_neg;
    wire logic [1:0] i_up_gain_sel_lo, o_target_addr;
    wire logic [3:0] o_dp_gain, o_up_gain, o_down_gain;
    int fail_count = 0, compares = 0, cyc = 0;
    amsc_top #(.HPD_LOW_CYC(LOW)) DUT (.*);
    amsc_board_model u_board (.i_clk(i_clk), .i_plug(plug), .i_addr0(addr0),
        .o_plug_detect(i_path_en_pin), .o_addr0_strap(i_up_gain_sel_lo));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #5;
    endtask
    task automatic close_out();
        $display("mismatches %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic restart(input logic [1:0] sel);
        i_nrst = 1'b0;
        i_bus_sel_strap = sel;
        tick(6);
        i_nrst = 1'b1;
        tick(2);
    endtask
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    // hang guard well above the expected run
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        restart(AMSC_LVL_0);
        for (int k = 0; k < 16; k++) begin
            {i_shared_clk_pin, i_shared_data_pin, plug, i_aux_listen_ctl} = k[3:0];
            tick(2);
            chk({o_flip, o_usb_path_ctl, o_dp_en, o_snoop_en}, k[3:0] ^ 4'h1);
            chk({o_sbu1_pos, o_sbu1_neg, o_sbu2_pos, o_sbu2_neg},
                k[1] ? (k[3] ? 4'h2 : 4'h8) : 4'h0);
        end
        for (int g = 0; g < 16; g++) begin
            {i_dp_gain_sel_hi, i_dp_gain_sel_lo} = g[3:0];
            {i_down_gain_sel_hi, i_down_gain_sel_lo} = ~g[3:0];
            {i_up_gain_sel_hi, addr0, i_usb_in_use} = g[3:0];
            tick(1);
            chk({o_dp_gain, o_down_gain}, {g[3:0], ~g[3:0]});
            chk({o_up_gain, o_down_gain_valid}, {g[3:2], {2{g[1]}}, g[0]});
        end
        i_bus_sel_strap = AMSC_LVL_F;
        tick(2);
        chk({o_serial_mode, o_target_addr}, 3'h0);
        restart(AMSC_LVL_F);
        {i_dp_gain_sel_lo, addr0, i_bus_sel_strap} = {2'h0, 1'b0, AMSC_LVL_0};
        {i_reg_dp_en, plug, i_shared_clk_pin, i_shared_data_pin} = 4'he;
        tick(2);
        chk({o_serial_mode, o_target_addr, o_serial_clk, o_serial_data, o_flip, o_snoop_en},
            8'h79);
        plug = 1'b0;
        tick(LOW - 2);
        chk({o_dp_en, o_dp_lanes_en, o_aux_switch_closed}, 3'h7);
        tick(6);
        chk({o_dp_en, o_dp_lanes_en, o_aux_switch_closed}, 3'h5);
        i_reg_dp_en = 1'b0;
        tick(1);
        chk({o_dp_en, o_aux_switch_closed}, 2'h0);
        {i_reg_dp_en, plug} = 2'h3;
        tick(3);
        chk({o_dp_en, o_dp_lanes_en, o_aux_switch_closed}, 3'h7);
        close_out();
    end
endmodule
`default_nettype wire
